// >>> csivm_mapper.sv
// Purpose: long packet framer with channel remap, two receive ports
// Assumes: receive inputs and link clock are asynchronous to pclk
// Notes: one line of 32 bytes buffered per port; longer lines truncate

// Operation
// - packet is header, payload bytes, footer
// - header: identifier, word count, ecc
// - ecc covers identifier and word count
// - word count equals payload byte count
// - footer is crc16 over payload
// - channel in top two identifier bits
// - data type in low six bits
// - packetized mode passes data type through
// - raw mode framed by line/frame valid
// - raw8, raw10, raw12 packings accepted
// - raw contexts hold channel per port
// - raw contexts low bits give type
// - multiplex up to four channels
// - per-port remap of incoming channel
// - one stream, sources told by channel
// - rate field selects lane rate
// - full rate scales with reference clock
// - auto lane timing at 800/full
// - 400 setting retunes pll, timers
// - full rate scales side timing
// - slow settings share bandwidth
module csivm_mapper import csivm_pkg::*; #(
	parameter int REFERENCE_CLOCK_INPUT_MHZ = 25
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic rx_link_clk,
	input wire logic [1:0][7:0] rx_data,
	input wire logic [1:0] rx_valid,
	input wire logic [1:0] rx_line_valid,
	input wire logic [1:0] rx_frame_valid,
	input wire logic [1:0][1:0] rx_vc,
	input wire logic [1:0][5:0] rx_dt,
	output logic [7:0] tx_data,
	output logic tx_valid,
	output logic tx_sop,
	output logic tx_eop,
	output logic [1:0] lane_rate_sel,
	output logic [11:0] lane_rate_mbps,
	output logic auto_lane_timing,
	output logic timing_override,
	output logic pll_retune,
	output logic reference_clock_input_scaled_timing,
	output logic shared_bandwidth
);

	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_HDR = 4'h2,
		ST_PAY = 4'h4,
		ST_CRC = 4'h8
	} csivm_state_t;

	typedef struct packed {
		logic lclk_s1;
		logic lclk_s2;
		logic lclk_d;
		logic [NPORT-1:0][18:0] in_s1;
		logic [NPORT-1:0][18:0] in_s2;
		logic [NPORT-1:0] lv_d;
		logic [NPORT-1:0] cap;
		logic [NPORT-1:0] line_rdy;
		logic [NPORT-1:0] ovf;
		logic [NPORT-1:0][5:0] wptr;
		logic [NPORT-1:0][5:0] len;
		logic [NPORT-1:0][7:0] di;
		logic [NPORT-1:0][LINE_DEPTH-1:0][7:0] buffer;
		logic [7:0] rate;
		logic [NPORT-1:0][7:0] ctx10;
		logic [NPORT-1:0][7:0] ctx12;
		logic [NPORT-1:0][7:0] remap;
		logic [7:0] cfg;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		csivm_state_t state;
		logic port;
		logic last_port;
		logic [5:0] cnt;
		logic [15:0] crc;
		logic [5:0] cur_len;
		logic [7:0] cur_di;
		logic [7:0] tx_data;
		logic tx_valid;
		logic tx_sop;
		logic tx_eop;
		logic pll_retune;
		logic auto_timing;
		logic reference_clock_input_scaled;
		logic bw_shared;
		logic [11:0] mbps;
	} csivm_st_t;

	csivm_st_t r;
	csivm_st_t n;

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		logic [18:0] v;
		logic raw;
		logic rise;
		logic cap_now;
		logic [5:0] wp;
		logic [7:0] ctx;
		logic [7:0] idx;
		logic hit;
		logic sel;
		logic p;
		logic [7:0] pb;
		logic [7:0] id;
		v = '0;
		raw = 1'b0;
		rise = 1'b0;
		cap_now = 1'b0;
		wp = '0;
		ctx = '0;
		idx = paddr[9:2];
		hit = 1'b0;
		sel = r.cfg[CFG_PSEL_BIT];
		p = 1'b0;
		pb = '0;
		id = '0;
		n = r;
		n.lclk_s1 = rx_link_clk;
		n.lclk_s2 = r.lclk_s1;
		n.lclk_d = r.lclk_s2;
		for (int i = 0; i < NPORT; i++) begin
			n.in_s1[i] = {rx_data[i], rx_valid[i], rx_line_valid[i], rx_frame_valid[i], rx_vc[i], rx_dt[i]};
		end
		n.in_s2 = r.in_s1;
		n.pready = 1'b0;
		n.pslverr = 1'b0;
		n.pll_retune = 1'b0;
		n.tx_valid = 1'b0;
		n.tx_sop = 1'b0;
		n.tx_eop = 1'b0;

		n.auto_timing = (r.rate[1:0] == RATE_FULL || r.rate[1:0] == RATE_800) && !r.rate[RATE_OVR_BIT];
		n.reference_clock_input_scaled = r.rate[1:0] == RATE_FULL;
		n.bw_shared = r.rate[1];
		case (r.rate[1:0])
			RATE_FULL: n.mbps = 12'(REFERENCE_CLOCK_INPUT_MHZ * REFERENCE_CLOCK_INPUT_MULT);
			RATE_800: n.mbps = MBPS_800;
			RATE_400: n.mbps = MBPS_400;
			default: n.mbps = '0;
		endcase

		// ****************************************
		// apb slave, one wait-free access phase
		// ****************************************
		hit = paddr[11:10] == 2'h0 && paddr[1:0] == 2'h0 && (idx == IDX_RATE || idx == IDX_CTX10
			|| idx == IDX_CTX12 || idx == IDX_REMAP || idx == IDX_CFG || idx == IDX_STATUS);
		if (psel && !penable) begin
			n.pready = 1'b1;
			n.pslverr = !hit;
			case (idx)
				IDX_RATE: n.prdata = {24'h0, r.rate};
				IDX_CTX10: n.prdata = {24'h0, r.ctx10[sel]};
				IDX_CTX12: n.prdata = {24'h0, r.ctx12[sel]};
				IDX_REMAP: n.prdata = {24'h0, r.remap[sel]};
				IDX_CFG: n.prdata = {24'h0, r.cfg};
				IDX_STATUS: n.prdata = {23'h0, r.bw_shared, 4'(r.state), r.ovf, r.line_rdy};
				default: n.prdata = '0;
			endcase
			if (!hit) begin
				n.prdata = '0;
			end
		end
		if (psel && penable && r.pready && pwrite && !r.pslverr) begin
			case (idx)
				IDX_RATE: begin
					n.rate = pwdata[7:0];
					n.pll_retune = pwdata[1:0] == RATE_400;
				end
				IDX_CTX10: n.ctx10[sel] = pwdata[7:0];
				IDX_CTX12: n.ctx12[sel] = pwdata[7:0];
				IDX_REMAP: n.remap[sel] = pwdata[7:0];
				IDX_CFG: n.cfg = pwdata[7:0];
				IDX_STATUS: n.ovf = r.ovf & ~pwdata[3:2];
				default: n.cfg = r.cfg;
			endcase
		end

		// ****************************************
		// packet transmitter
		// ****************************************
		case (r.state)
			ST_IDLE: begin
				if (|r.line_rdy) begin
					p = r.line_rdy[!r.last_port] ? !r.last_port : r.last_port;
					n.port = p;
					n.last_port = p;
					n.cur_len = r.len[p];
					n.cur_di = r.di[p];
					n.cnt = '0;
					n.state = ST_HDR;
				end
			end
			ST_HDR: begin
				n.tx_valid = 1'b1;
				n.cnt = 6'(r.cnt + 6'h01);
				case (r.cnt[1:0])
					2'h0: begin
						n.tx_data = r.cur_di;
						n.tx_sop = 1'b1;
					end
					2'h1: n.tx_data = {2'h0, r.cur_len};
					2'h2: n.tx_data = 8'h00;
					default: n.tx_data = {2'h0, csivm_ecc({8'h00, 2'h0, r.cur_len, r.cur_di})};
				endcase
				if (r.cnt == HDR_LAST) begin
					n.cnt = '0;
					n.crc = CRC_SEED;
					n.state = (r.cur_len == 6'h00) ? ST_CRC : ST_PAY;
				end
			end
			ST_PAY: begin
				pb = r.buffer[r.port][r.cnt[4:0]];
				n.tx_valid = 1'b1;
				n.tx_data = pb;
				n.crc = csivm_crc(r.crc, pb);
				n.cnt = 6'(r.cnt + 6'h01);
				if (r.cnt == 6'(r.cur_len - 6'h01)) begin
					n.cnt = '0;
					n.state = ST_CRC;
				end
			end
			ST_CRC: begin
				n.tx_valid = 1'b1;
				if (r.cnt == 6'h00) begin
					n.tx_data = r.crc[7:0];
					n.cnt = 6'h01;
				end else begin
					n.tx_data = r.crc[15:8];
					n.tx_eop = 1'b1;
					n.line_rdy[r.port] = 1'b0;
					n.state = ST_IDLE;
				end
			end
			default: n.state = ST_IDLE;
		endcase

		// ****************************************
		// line capture on link clock rising edge
		// ****************************************
		for (int i = 0; i < NPORT; i++) begin
			v = r.in_s2[i];
			raw = r.cfg[2*i +: 2] != MODE_PKT;
			ctx = (r.cfg[2*i +: 2] == MODE_RAW12) ? r.ctx12[i] : r.ctx10[i];
			id = raw ? ctx : {r.remap[i][{v[7:6], 1'b0} +: 2], v[5:0]};
			if (r.lclk_s2 && !r.lclk_d) begin
				n.lv_d[i] = v[9];
				rise = v[9] && !r.lv_d[i];
				cap_now = rise ? (!r.line_rdy[i] && (!raw || v[8])) : r.cap[i];
				wp = rise ? 6'h00 : r.wptr[i];
				n.cap[i] = cap_now;
				n.wptr[i] = wp;
				// id at line start, else empty lines go stale
				if (rise && cap_now) begin
					n.di[i] = id;
				end
				if (rise && r.line_rdy[i]) begin
					n.ovf[i] = 1'b1;
				end
				if (v[9] && cap_now && v[10]) begin
					if (wp == LINE_FULL) begin
						n.ovf[i] = 1'b1;
					end else begin
						n.buffer[i][wp[4:0]] = v[18:11];
						n.wptr[i] = 6'(wp + 6'h01);
					end
					if (wp == 6'h00) begin
						n.di[i] = id;
					end
				end
				if (!v[9] && r.lv_d[i] && r.cap[i]) begin
					n.cap[i] = 1'b0;
					n.line_rdy[i] = 1'b1;
					n.len[i] = r.wptr[i];
				end
			end
		end
	end

	// ****************************************
	// state register
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r <= '0;
			r.state <= ST_IDLE;
			r.rate <= RST_RATE;
			r.ctx10 <= {RST_CTX, RST_CTX};
			r.ctx12 <= {RST_CTX, RST_CTX};
			r.remap <= {RST_REMAP, RST_REMAP};
			r.cfg <= RST_CFG;
		end else begin
			r <= n;
		end
	end

	assign prdata = r.prdata;
	assign pready = r.pready;
	assign pslverr = r.pslverr;
	assign tx_data = r.tx_data;
	assign tx_valid = r.tx_valid;
	assign tx_sop = r.tx_sop;
	assign tx_eop = r.tx_eop;
	assign lane_rate_sel = r.rate[1:0];
	assign lane_rate_mbps = r.mbps;
	assign auto_lane_timing = r.auto_timing;
	assign timing_override = r.rate[RATE_OVR_BIT];
	assign pll_retune = r.pll_retune;
	assign reference_clock_input_scaled_timing = r.reference_clock_input_scaled;
	assign shared_bandwidth = r.bw_shared;

	// ****************************************
	// checks
	// ****************************************
	hdr_length_a: assert property (@(posedge pclk) disable iff (!presetn)
		tx_sop |-> tx_valid [*4] ##1 tx_valid)
		else $error("header shorter than four bytes");
	wc_field_a: assert property (@(posedge pclk) disable iff (!presetn)
		tx_sop |=> tx_data == {2'h0, r.cur_len} ##1 tx_data == 8'h00)
		else $error("word count byte wrong");
	ecc_byte_a: assert property (@(posedge pclk) disable iff (!presetn)
		tx_sop |-> ##3 tx_data == {2'h0, csivm_ecc({8'h00, 2'h0, r.cur_len, r.cur_di})})
		else $error("header ecc wrong");
	raw_context_a: assert property (@(posedge pclk) disable iff (!presetn)
		tx_sop && r.cfg[2*r.port +: 2] == MODE_RAW12 |-> tx_data == r.ctx12[r.port])
		else $error("raw context byte wrong");
	eop_close_a: assert property (@(posedge pclk) disable iff (!presetn)
		tx_eop |-> $past(tx_valid) && !tx_sop ##1 !tx_valid)
		else $error("footer not closing packet");
	pll_retune_a: assert property (@(posedge pclk) disable iff (!presetn)
		pll_retune |-> lane_rate_sel == RATE_400 ##1 !pll_retune)
		else $error("retune without 400 setting");
	auto_timing_a: assert property (@(posedge pclk) disable iff (!presetn)
		lane_rate_sel == RATE_800 && !timing_override |=> auto_lane_timing)
		else $error("auto timing missing at 800");
	full_rate_a: assert property (@(posedge pclk) disable iff (!presetn)
		lane_rate_sel == RATE_FULL |=> lane_rate_mbps == 12'(REFERENCE_CLOCK_INPUT_MHZ * REFERENCE_CLOCK_INPUT_MULT) && reference_clock_input_scaled_timing)
		else $error("full rate not scaled from reference_clock_input");
	apb_answer_a: assert property (@(posedge pclk) disable iff (!presetn)
		psel && !penable |=> pready ##1 !pready)
		else $error("apb answer not one cycle");

endmodule

// >>> csivm_pkg.sv
// Purpose: constants and helpers for the long packet framer
// Assumes: apb data 32 bits, register index = byte address / 4
// Notes: masks and polynomial are fixed by the packet format
package csivm_pkg;

	// ****************************************
	// register map (word index)
	// ****************************************
	localparam logic [7:0] IDX_RATE = 8'h1f;
	localparam logic [7:0] IDX_CTX10 = 8'h70;
	localparam logic [7:0] IDX_CTX12 = 8'h71;
	localparam logic [7:0] IDX_REMAP = 8'h72;
	localparam logic [7:0] IDX_CFG = 8'h80;
	localparam logic [7:0] IDX_STATUS = 8'h81;

	localparam logic [7:0] RST_RATE = 8'h00;
	localparam logic [7:0] RST_CTX = 8'h00;
	localparam logic [7:0] RST_REMAP = 8'he4;
	localparam logic [7:0] RST_CFG = 8'h00;

	// ****************************************
	// fields and encodings
	// ****************************************
	localparam logic [1:0] RATE_FULL = 2'h0;
	localparam logic [1:0] RATE_800 = 2'h2;
	localparam logic [1:0] RATE_400 = 2'h3;
	localparam int RATE_OVR_BIT = 2;
	localparam int CFG_PSEL_BIT = 4;
	localparam logic [11:0] MBPS_800 = 12'h320;
	localparam logic [11:0] MBPS_400 = 12'h190;
	localparam int REFERENCE_CLOCK_INPUT_MULT = 64;

	localparam logic [1:0] MODE_PKT = 2'h0;
	localparam logic [1:0] MODE_RAW8 = 2'h1;
	localparam logic [1:0] MODE_RAW10 = 2'h2;
	localparam logic [1:0] MODE_RAW12 = 2'h3;

	localparam int NPORT = 2;
	localparam int LINE_DEPTH = 32;
	localparam logic [5:0] LINE_FULL = 6'h20;
	localparam logic [5:0] HDR_LAST = 6'h03;

	localparam logic [15:0] CRC_SEED = 16'hffff;
	localparam logic [15:0] CRC_POLY = 16'h8408;
	localparam logic [5:0][23:0] ECC_MASK = {24'heffc00, 24'hdf03f0, 24'hb8e38e,
		24'h749a6d, 24'hf2555b, 24'hf12cb7};

	// ****************************************
	// header code and payload checksum
	// ****************************************
	function automatic logic [5:0] csivm_ecc(input logic [23:0] d);
		logic [5:0] e;
		e = '0;
		for (int i = 0; i < 6; i++) begin
			e[i] = ^(d & ECC_MASK[i]);
		end
		return e;
	endfunction

	function automatic logic [15:0] csivm_crc(input logic [15:0] c, input logic [7:0] b);
		logic [15:0] x;
		x = c;
		for (int i = 0; i < 8; i++) begin
			if (x[0] ^ b[i]) begin
				x = (x >> 1) ^ CRC_POLY;
			end else begin
				x = x >> 1;
			end
		end
		return x;
	endfunction

endpackage

// >>> csivm_sink.sv
// Purpose: downstream receiver model, catches packets
// Assumes: no back-pressure, every valid byte is taken
// Notes: a gap inside a packet counts as a fault
module csivm_sink (
	input wire logic pclk,
	input wire logic [7:0] tx_data,
	input wire logic tx_valid,
	input wire logic tx_sop,
	input wire logic tx_eop
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] got_q[$];
	int len_q[$];
	int gaps = 0;
	int cnt = 0;
	// ****************
	// packet capture
	// ****************
	always @(posedge pclk) begin
		// contiguous bytes from start to end mark
		if (tx_valid === 1'b1) begin
			got_q.push_back(tx_data);
			cnt = (tx_sop === 1'b1) ? 1 : cnt + 1;
			if (tx_eop === 1'b1) begin
				len_q.push_back(cnt);
				cnt = 0;
			end
		end else if (cnt > 0) begin
			gaps++;
		end
	end
endmodule

// >>> tb_top.sv
// Purpose: self-checking bench for the packet framer
// Assumes: link clock runs only during send, including three idle steps after each line
// Notes: ports told apart by identifier byte
module tb_top import csivm_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int REF = 26;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rx_link_clk, tx_valid, tx_sop, tx_eop;
	logic auto_lane_timing, timing_override, pll_retune, reference_clock_input_scaled_timing, shared_bandwidth;
	logic [11:0] paddr, lane_rate_mbps;
	logic [31:0] pwdata, prdata, seed = 32'h27;
	logic [1:0][7:0] rx_data;
	logic [1:0][1:0] rx_vc;
	logic [1:0][5:0] rx_dt;
	logic [1:0] rx_valid, rx_line_valid, rx_frame_valid, lane_rate_sel;
	logic [7:0] tx_data, ctx10[2], ctx12[2], remap[2], exq[2][$];
	logic [1:0] mode[2], vc[2];
	logic [5:0] dt[2];
	int elen[2][$];
	int failures = 0, cmp_count = 0, cyc = 0;
	csivm_mapper #(.REFERENCE_CLOCK_INPUT_MHZ(REF)) i_dut (.*);
	csivm_sink i_sink (.*);
	// ****************
	// clock, helpers, tests
	// ****************
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cyc++;
		// tests need well under half of this
		if (cyc == 20000) begin
			failures++;
			conclude();
		end
	end
	function automatic logic [7:0] xb();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction
	function automatic logic [7:0] ecc8(input logic [23:0] d);
		logic [7:0] e = 8'h00;
		for (int i = 0; i < 6; i++)
			e[i] = ^(d & ECC_MASK[i]);
		return e;
	endfunction
	function automatic logic [15:0] crc(input logic [15:0] c, input logic [7:0] b);
		for (int i = 0; i < 8; i++)
			c = (c[0] ^ b[i]) ? (c >> 1) ^ CRC_POLY : c >> 1;
		return c;
	endfunction
	function automatic logic [7:0] idb(input int p);
		return mode[p] == MODE_PKT ? {remap[p][2 * vc[p] +: 2], dt[p]} : mode[p] == MODE_RAW12 ? ctx12[p] : ctx10[p];
	endfunction
	task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			failures++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d, input logic [31:0] x, input logic xe);
		int k = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1);
		cmp("pready_wait", 1, k);
		cmp("pslverr", xe, pslverr);
		if (!w)
			cmp("prdata", x, prdata);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic setp(input int p, input logic [7:0] rm);
		ctx10[p] = xb();
		ctx12[p] = xb();
		remap[p] = rm;
		apb(1'b1, 12'h200, {3'h0, 1'(p), mode[1], mode[0]}, 8'h00, 1'b0);
		apb(1'b1, 12'h1c0, ctx10[p], 8'h00, 1'b0);
		apb(1'b1, 12'h1c4, ctx12[p], 8'h00, 1'b0);
		apb(1'b1, 12'h1c8, rm, 8'h00, 1'b0);
		apb(1'b0, 12'h1c4, 8'h00, ctx12[p], 1'b0);
	endtask
	task automatic lstep(input logic [1:0] lv, input logic [1:0] fv, input logic [1:0] vl, input logic [1:0][7:0] d);
		@(posedge pclk);
		rx_link_clk <= 1'b0;
		rx_line_valid <= lv;
		rx_frame_valid <= fv;
		rx_valid <= vl;
		rx_data <= d;
		repeat (4) @(posedge pclk);
		rx_link_clk <= 1'b1;
		repeat (3) @(posedge pclk);
	endtask
	task automatic send(input logic [1:0] m, input int n, input logic fv);
		logic [1:0][7:0] d;
		logic [15:0] c[2];
		logic [1:0] ex;
		logic [7:0] w;
		w = 8'(n > 32 ? 32 : n);
		@(posedge pclk);
		rx_vc <= {vc[1], vc[0]};
		rx_dt <= {dt[1], dt[0]};
		for (int p = 0; p < 2; p++) begin
			// raw line without frame valid is dropped
			ex[p] = m[p] && (fv || mode[p] == MODE_PKT);
			c[p] = CRC_SEED;
			if (ex[p]) begin
				exq[p] = {exq[p], idb(p), w, 8'h00, ecc8({8'h00, w, idb(p)})};
				elen[p].push_back(int'(w) + 6);
			end
		end
		for (int i = 0; i < (n > 0 ? n : 1); i++) begin
			for (int p = 0; p < 2; p++) begin
				d[p] = xb();
				if (ex[p] && n > 0 && i < 32) begin
					exq[p].push_back(d[p]);
					c[p] = crc(c[p], d[p]);
				end
			end
			lstep(m, fv ? m : 2'b00, n > 0 ? m : 2'b00, d);
		end
		for (int p = 0; p < 2; p++) begin
			if (ex[p]) begin
				exq[p].push_back(c[p][7:0]);
				exq[p].push_back(c[p][15:8]);
			end
		end
		repeat (3) lstep(2'b00, 2'b00, 2'b00, ~d);
	endtask
	task automatic take();
		int k = 0;
		int n;
		int p;
		while (i_sink.len_q.size() == 0 && k < 2000) begin
			@(posedge pclk);
			k++;
		end
		n = k < 2000 ? i_sink.len_q.pop_front() : 0;
		p = elen[1].size() > 0 && exq[1][0] === i_sink.got_q[0];
		cmp("packet_length", elen[p].pop_front(), n);
		for (int i = 0; i < n; i++)
			cmp("packet_byte", exq[p].pop_front(), i_sink.got_q.pop_front());
	endtask
	task automatic conclude();
		$display("comparisons %0d failures %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	initial begin
		logic [11:0] ra[7] = '{12'h07c, 12'h1c0, 12'h1c4, 12'h1c8, 12'h200, 12'h3fc, 12'h07d};
		logic [7:0] rv[7] = '{RST_RATE, RST_CTX, RST_CTX, RST_REMAP, RST_CFG, 8'h00, 8'h00};
		int lens[4] = '{0, 1, 32, 34};
		logic [2:0] r;
		int k;
		{presetn, psel, penable, pwrite, rx_link_clk, paddr, pwdata, rx_data, rx_valid, rx_line_valid} = '0;
		{rx_frame_valid, rx_vc, rx_dt} = '0;
		mode = '{MODE_PKT, MODE_PKT};
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 7; i++)
			apb(1'b0, ra[i], 8'h00, rv[i], i > 4);
		$display("test registers done");
		for (int i = 0; i < 8; i++) begin
			r = 3'(i);
			k = 0;
			// override bit set in the upper four passes, for every rate
			apb(1'b1, 12'h07c, {5'h00, r}, 8'h00, 1'b0);
			repeat (4) begin
				@(negedge pclk);
				k += int'(pll_retune === 1'b1);
			end
			cmp("pll_retune", r[1:0] == 2'h3, k);
			cmp("lane_rate_sel", r[1:0], lane_rate_sel);
			cmp("lane_rate_mbps", r[1:0] == 2'h0 ? REF * 64 : r[0] ? (r[1] ? 400 : 0) : 800, lane_rate_mbps);
			cmp("auto_lane_timing", !r[2] && !r[0], auto_lane_timing);
			cmp("timing_override", r[2], timing_override);
			cmp("reference_clock_input_scaled", r[1:0] == 2'h0, reference_clock_input_scaled_timing);
			cmp("shared_bandwidth", r[1], shared_bandwidth);
			apb(1'b0, 12'h07c, 8'h00, {5'h00, r}, 1'b0);
		end
		$display("test lane rate done");
		setp(0, xb());
		setp(1, xb());
		for (int i = 0; i < 6; i++) begin
			vc[i % 2] = 2'(xb());
			dt[i % 2] = 6'(xb());
			send(2'(1 << (i % 2)), i < 4 ? lens[i] : 1 + int'(xb()) % 31, 1'b1);
			take();
		end
		// 34-byte line on port 1 left its overflow flag; clear is write-one
		apb(1'b0, 12'h204, 8'h00, 32'h118, 1'b0);
		apb(1'b1, 12'h204, 8'h0c, 8'h00, 1'b0);
		apb(1'b0, 12'h204, 8'h00, 32'h110, 1'b0);
		$display("test packetized done");
		vc = '{2'h0, 2'h0};
		setp(0, 8'h1b);
		setp(1, 8'he4);
		send(2'b11, 8, 1'b1);
		take();
		take();
		$display("test two ports done");
		for (int i = 1; i < 4; i++) begin
			mode[1] = 2'(i);
			setp(1, xb());
			send(2'b10, 1 + int'(xb()) % 32, 1'b1);
			take();
		end
		send(2'b10, 4, 1'b0);
		repeat (100) @(posedge pclk);
		cmp("dropped_line", 0, i_sink.len_q.size());
		cmp("valid_gaps", 0, i_sink.gaps);
		$display("test raw modes done");
		conclude();
	end
endmodule
